// >>> verilog/reset_cause_defines.svh
// Constants for the reset cause controller: cause bit positions and timing counts.
`ifndef RESET_CAUSE_DEFINES_SVH
`define RESET_CAUSE_DEFINES_SVH
// Cause bit positions in the cause record.
`define CAUSE_BROWNOUT   0
`define CAUSE_POWERON    1
`define CAUSE_PIN        2
`define CAUSE_WAKE_INT   3
`define CAUSE_KEYPAD     4
`define CAUSE_SOFTWARE   5
`define CAUSE_WATCHDOG   6
`define CAUSE_WAKEUP_TMR 7
// Reset value of the cause record and of the enable mask.
`define CAUSE_RESET_VAL  8'h02
`define ENABLE_RESET_VAL 5'h1F
// Timing: clock period in ns, reinit bound in ns, watchdog period in ns.
`define CLK_PERIOD_NS    4
`define REINIT_MAX_NS    1000000
`define WDOG_PERIOD_NS   1000000000
`define REINIT_CYCLES    (`REINIT_MAX_NS / `CLK_PERIOD_NS)
`define WDOG_CYCLES      (`WDOG_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// >>> verilog/reset_cause_pkg.sv
// Types shared by the reset cause controller.
package reset_cause_pkg;
    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_HOLD = 3'b010,
        ST_WAIT = 3'b100
    } seq_state_e;
    typedef struct packed {
        logic keypad;
        logic wake_int;
        logic software;
        logic watchdog;
        logic wakeup_tmr;
    } mask_s;
endpackage : reset_cause_pkg

// >>> verilog/reset_cause_controller.sv
// Reset cause controller: collects reset requests, sequences the core reset, records the cause.
//
// Overview of operation
// - Reinit wait counts up to one millisecond, but release still waits for the oscillator.
// - Latch the latest reset cause for software.
// - Brown-out reset unmaskable, pins go pulled-up.
// - Power-on reset unmaskable, pins go pulled-up.
// - Pin reset unmaskable, fires while low, cause recorded on release.
// - Wake pin in power down, maskable, pins kept.
// - Keypad row low in power down, maskable.
// - Software reset maskable, pins kept.
// - Watchdog expiry maskable, pins go pulled-up.
// - Wake-up timer expiry maskable, pins kept.
// - Watchdog on from reset, one second, stops asleep.
`timescale 1ns/1ps
`include "reset_cause_defines.svh"
module reset_cause_controller #(
    parameter int ROWS        = 8,
    parameter int REINIT_CYC  = `REINIT_CYCLES,
    parameter int WDOG_CYC    = `WDOG_CYCLES
) (
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    input  wire logic                  brownout_reset_request,
    input  wire logic                  reset_pin_n,
    input  wire logic                  external_wake_interrupt_pin,
    input  wire logic [ROWS-1:0]       keypad_row_input,
    input  wire logic                  osc_stable,
    input  wire logic                  power_down,
    input  wire logic                  software_reset,
    input  wire logic                  watchdog_clear,
    input  wire logic                  wakeup_timer_expired,
    input  wire reset_cause_pkg::mask_s cause_enable,
    output logic                       core_reset_n,
    output logic                       gpio_pullup_reset,
    output logic [7:0]                 cause_record,
    output logic                       watchdog_expired
);
    // ************************************************************
    // Input synchronizers
    // ************************************************************
    localparam int NS = 4 + ROWS;
    // Idle level of each raw input: rows and the reset pin idle high, the rest low.
    // Waking the flops at these levels keeps the pin release detector from seeing
    // a false edge right after reset.
    localparam logic [NS-1:0] SYNC_IDLE = {{ROWS{1'b1}}, 4'h2};
    logic [NS-1:0] sync1_reg;
    logic [NS-1:0] sync2_reg;
    logic [NS-1:0] sync_in;
    logic          por_meta_reg;
    logic          por_done_reg;

    // Raw asynchronous inputs gathered for two-flop synchronization.
    assign sync_in = {keypad_row_input, osc_stable, external_wake_interrupt_pin,
                      reset_pin_n, brownout_reset_request};

    // Two-flop synchronizers; the power-on flop pair releases after arst_n rises.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg    <= SYNC_IDLE;
            sync2_reg    <= SYNC_IDLE;
            por_meta_reg <= 1'b0;
            por_done_reg <= 1'b0;
        end else begin
            sync1_reg    <= sync_in;
            sync2_reg    <= sync1_reg;
            por_meta_reg <= 1'b1;
            por_done_reg <= por_meta_reg;
        end
    end

    logic brown_s;
    logic pin_s;
    logic wake_s;
    logic osc_s;
    logic [ROWS-1:0] row_s;
    assign brown_s = sync2_reg[0];
    assign pin_s  = sync2_reg[1];
    assign wake_s = sync2_reg[2];
    assign osc_s  = sync2_reg[3];
    assign row_s  = sync2_reg[NS-1:4];

    // ************************************************************
    // Request decode and sequencer
    // ************************************************************
    logic                    pin_prev_reg;
    logic                    pin_prev_next;
    reset_cause_pkg::seq_state_e state_reg;
    reset_cause_pkg::seq_state_e state_next;
    logic [19:0]             cnt_reg;
    logic [19:0]             cnt_next;
    logic [7:0]              req;
    logic                    any_req;
    logic                    pullup_req;
    logic [7:0]              cause_reg;
    logic [7:0]              cause_next;
    logic                    core_n_reg;
    logic                    core_n_next;
    logic                    pullup_reg;
    logic                    pullup_next;
    logic                    wdog_hit;

    // Requests per cause, masked causes are dropped entirely.
    always_comb begin
        req = '0;
        req[`CAUSE_BROWNOUT]   = brown_s;
        req[`CAUSE_POWERON]    = 1'b0;
        req[`CAUSE_PIN]        = pin_s && !pin_prev_reg;
        req[`CAUSE_WAKE_INT]   = power_down && wake_s && cause_enable.wake_int;
        req[`CAUSE_KEYPAD]     = power_down && !(&row_s) && cause_enable.keypad;
        req[`CAUSE_SOFTWARE]   = software_reset && cause_enable.software;
        req[`CAUSE_WATCHDOG]   = wdog_hit && cause_enable.watchdog;
        req[`CAUSE_WAKEUP_TMR] = wakeup_timer_expired && cause_enable.wakeup_tmr;
        any_req    = |req;
        pullup_req = req[`CAUSE_BROWNOUT] | req[`CAUSE_PIN] | req[`CAUSE_WATCHDOG];
    end

    // Sequencer: hold core reset while the pin is low, then count until the oscillator is stable.
    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        cause_next    = cause_reg;
        core_n_next   = core_n_reg;
        pullup_next   = pullup_reg;
        pin_prev_next = pin_s;
        case (state_reg)
            reset_cause_pkg::ST_RUN: begin
                if (!pin_s || any_req) begin
                    state_next  = reset_cause_pkg::ST_HOLD;
                    core_n_next = 1'b0;
                    pullup_next = !pin_s || pullup_req;
                    if (any_req) begin
                        cause_next = req;
                    end
                end
            end
            reset_cause_pkg::ST_HOLD: begin
                if (brown_s || !pin_s) begin
                    pullup_next = 1'b1;
                end else begin
                    if (pin_s && !pin_prev_reg) begin
                        cause_next = 8'h04;
                    end
                    state_next = reset_cause_pkg::ST_WAIT;
                    cnt_next   = '0;
                end
            end
            reset_cause_pkg::ST_WAIT: begin
                if (brown_s || !pin_s) begin
                    state_next = reset_cause_pkg::ST_HOLD;
                end else if (osc_s && por_done_reg) begin
                    state_next  = reset_cause_pkg::ST_RUN;
                    core_n_next = 1'b1;
                    pullup_next = 1'b0;
                end else if (cnt_reg < 20'(REINIT_CYC - 1)) begin
                    cnt_next = cnt_reg + 20'h00001;
                end
            end
            default: begin
                state_next = reset_cause_pkg::ST_HOLD;
            end
        endcase
    end

    // Sequencer registers; power-on leaves the core held with pull-ups and power-on recorded.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg    <= reset_cause_pkg::ST_WAIT;
            cnt_reg      <= '0;
            cause_reg    <= `CAUSE_RESET_VAL;
            core_n_reg   <= 1'b0;
            pullup_reg   <= 1'b1;
            pin_prev_reg <= 1'b1;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            cause_reg    <= cause_next;
            core_n_reg   <= core_n_next;
            pullup_reg   <= pullup_next;
            pin_prev_reg <= pin_prev_next;
        end
    end

    // ************************************************************
    // Watchdog
    // ************************************************************
    logic [27:0] wdog_reg;
    logic [27:0] wdog_next;
    logic        wexp_reg;
    logic        wexp_next;

    // Watchdog counts while running; cleared by firmware, in power down, and in reset.
    always_comb begin
        wdog_hit  = (wdog_reg == 28'(WDOG_CYC - 1));
        wexp_next = wdog_hit;
        if (!core_n_reg || power_down || watchdog_clear || wdog_hit) begin
            wdog_next = '0;
        end else begin
            wdog_next = wdog_reg + 28'h0000001;
        end
    end

    // Watchdog registers.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wdog_reg <= '0;
            wexp_reg <= 1'b0;
        end else begin
            wdog_reg <= wdog_next;
            wexp_reg <= wexp_next;
        end
    end

    assign core_reset_n      = core_n_reg;
    assign gpio_pullup_reset = pullup_reg;
    assign cause_record      = cause_reg;
    assign watchdog_expired  = wexp_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_RELEASE_NEEDS_OSC: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(core_n_reg) |-> $past(osc_s))
        else $error("Core reset released without stable oscillator.");
    AST_BROWN_HOLDS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        brown_s |=> !core_n_reg && pullup_reg)
        else $error("Brown-out did not hold reset with pull-ups.");
    AST_SW_MASKED: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (core_n_reg && software_reset && !cause_enable.software && !any_req && pin_s)
        |=> core_n_reg)
        else $error("Masked software request reset the core.");
    AST_SW_KEEPS_PINS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state_reg == reset_cause_pkg::ST_RUN && req == 8'h20 && pin_s)
        |=> !pullup_reg && cause_reg == 8'h20)
        else $error("Software reset changed pins or cause.");
    AST_WDOG_PULLUP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state_reg == reset_cause_pkg::ST_RUN && req[`CAUSE_WATCHDOG]) |=> pullup_reg)
        else $error("Watchdog reset did not enable pull-ups.");
    AST_WAKE_TMR_CAUSE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state_reg == reset_cause_pkg::ST_RUN && req == 8'h80 && pin_s) |=> cause_reg == 8'h80)
        else $error("Wake-up timer cause not recorded.");
    AST_WAKE_PD_ONLY: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !power_down |-> !req[`CAUSE_WAKE_INT] && !req[`CAUSE_KEYPAD])
        else $error("Wake request outside power down.");
    AST_KEYPAD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state_reg == reset_cause_pkg::ST_RUN && req == 8'h10 && pin_s)
        |=> !core_n_reg && !pullup_reg && cause_reg == 8'h10)
        else $error("Keypad press in power down gave no reset with pins kept.");
    AST_WDOG_STOP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        power_down |=> wdog_reg == '0)
        else $error("Watchdog ran in power down.");
    AST_PIN_RELEASE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state_reg == reset_cause_pkg::ST_HOLD && pin_s && !pin_prev_reg && !brown_s)
        |=> cause_reg == 8'h04 && state_reg == reset_cause_pkg::ST_WAIT)
        else $error("Pin release not recorded.");
    AST_REINIT_BOUND: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_reg == reset_cause_pkg::ST_WAIT |-> cnt_reg < 20'(REINIT_CYC - 1))
        else $error("Reinitialization wait ran to its time limit.");
    COV_RELEASE: cover property (@(posedge ref_clk) disable iff (!arst_n) $rose(core_n_reg));
    COV_WDOG: cover property (@(posedge ref_clk) disable iff (!arst_n) req[`CAUSE_WATCHDOG]);
    COV_PIN: cover property (@(posedge ref_clk) disable iff (!arst_n) $fell(pin_s));
    COV_KEY: cover property (@(posedge ref_clk) disable iff (!arst_n) req[`CAUSE_KEYPAD]);
endmodule : reset_cause_controller

// >>> verification/reset_source_model.sv
// Model of the far-side sources: the external reset pin and the crystal oscillator.
`timescale 1ns/1ps
module reset_source_model #(
    parameter int OSC_DLY = 40
) (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic pin_hold,
    output logic      reset_pin_n,
    output logic      osc_stable
);
    int cnt = 0;
    // The pin is pulled low only while held; once released its pull-up brings it high.
    assign reset_pin_n = ~pin_hold;
    // A power-on restarts the oscillator, which settles OSC_DLY cycles later.
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 0;
        end else if (cnt < OSC_DLY) begin
            cnt <= cnt + 1;
        end
    end
    assign osc_stable = (cnt >= OSC_DLY);
endmodule : reset_source_model

// >>> verification/tb.sv
// Self-checking testbench for the reset cause controller.
`timescale 1ns/1ps
module tb;
    localparam int WDOG = 64;
    localparam int OSC_DLY = 40;
    typedef struct packed {
        logic [4:0] en;
        logic [2:0] src;
        logic       pd;
        logic [7:0] cause;
        logic       pull;
    } row_s;
    logic ref_clk = 0, arst_n = 0, brown = 0, pin_hold = 0, wake = 0, pd = 0;
    logic sw = 0, wdc = 0, tmr = 0, feed = 1, core_n, pull, wexp, pin_n, osc;
    logic [7:0] keys = 8'hFF, cause, last = 8'h02;
    reset_cause_pkg::mask_s en = 5'h1F;
    int failures = 0, cmp_count = 0, tick = 0, n;
    // Ordinary cases: mask, source, power down, expected cause (0 = no reset), pull-up.
    row_s rows [11] = '{'{5'h1F,3'h0,1'b0,8'h20,1'b0}, '{5'h1F,3'h1,1'b0,8'h80,1'b0},
        '{5'h1F,3'h2,1'b1,8'h08,1'b0}, '{5'h1F,3'h3,1'b1,8'h10,1'b0},
        '{5'h00,3'h4,1'b0,8'h01,1'b1}, '{5'h1B,3'h0,1'b0,8'h00,1'b0},
        '{5'h1E,3'h1,1'b0,8'h00,1'b0}, '{5'h17,3'h2,1'b1,8'h00,1'b0},
        '{5'h0F,3'h3,1'b1,8'h00,1'b0}, '{5'h1F,3'h2,1'b0,8'h00,1'b0},
        '{5'h1F,3'h3,1'b0,8'h00,1'b0}};

    reset_cause_controller #(.ROWS(8), .REINIT_CYC(400), .WDOG_CYC(WDOG)) dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .brownout_reset_request(brown),
        .reset_pin_n(pin_n), .external_wake_interrupt_pin(wake), .keypad_row_input(keys),
        .osc_stable(osc), .power_down(pd), .software_reset(sw), .watchdog_clear(wdc),
        .wakeup_timer_expired(tmr), .cause_enable(en), .core_reset_n(core_n),
        .gpio_pullup_reset(pull), .cause_record(cause), .watchdog_expired(wexp));
    reset_source_model #(.OSC_DLY(OSC_DLY)) far (.ref_clk(ref_clk), .arst_n(arst_n),
        .pin_hold(pin_hold), .reset_pin_n(pin_n), .osc_stable(osc));

    // ****************************************
    // Clock, watchdog feeding and helpers.
    // ****************************************
    initial forever #2 ref_clk = ~ref_clk;
    initial forever begin
        step();
        tick++;
        wdc = feed && (tick % 16 == 0);
    end
    task step;
        @(posedge ref_clk);
        #1;
    endtask : step
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Waits a bounded time for the core to leave reset.
    task wait_rel;
        n = 0;
        while (core_n !== 1'b1 && n < 400) begin
            step();
            n++;
        end
        check("release", {7'h0, core_n}, 8'h01);
    endtask : wait_rel
    task drive(input logic [2:0] s, input logic v);
        case (s)
            3'h0: sw = v;
            3'h1: tmr = v;
            3'h2: wake = v;
            3'h3: keys = v ? 8'hFB : 8'hFF;
            default: brown = v;
        endcase
    endtask : drive
    task stop_test;
        if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    initial begin
        #100000;
        failures++;
        stop_test();
    end

    // ****************************************
    // Main sequence.
    // ****************************************
    initial begin
        repeat (16) step();
        check("cause_por", cause, 8'h02);
        check("pull_por", {7'h0, pull}, 8'h01);
        arst_n = 1;
        wait_rel();
        check("osc_gate", {7'h0, n >= OSC_DLY}, 8'h01);
        check("cause_after_por", cause, 8'h02);
        foreach (rows[i]) begin
            en = rows[i].en;
            pd = rows[i].pd;
            step();
            drive(rows[i].src, 1'b1);
            n = 0;
            while (core_n !== 1'b0 && n < 12) begin
                step();
                n++;
            end
            check("core_reset_n", {7'h0, core_n}, {7'h0, rows[i].cause == 8'h0});
            if (rows[i].cause != 8'h0) last = rows[i].cause;
            check("cause_record", cause, last);
            if (rows[i].cause != 8'h0) check("pull", {7'h0, pull}, {7'h0, rows[i].pull});
            drive(rows[i].src, 1'b0);
            pd = 0;
            wait_rel();
            // Let the input synchronizers drain before the next row raises power down.
            repeat (3) step();
        end
        pin_hold = 1;
        repeat (10) step();
        check("pin_hold_core", {7'h0, core_n}, 8'h00);
        check("pin_pull", {7'h0, pull}, 8'h01);
        pin_hold = 0;
        wait_rel();
        check("pin_cause", cause, 8'h04);
        feed = 0;
        n = 0;
        while (wexp !== 1'b1 && n < 200) begin
            step();
            n++;
        end
        feed = 1;
        check("wdog_period", {7'h0, n >= WDOG - 20 && n <= WDOG + 4}, 8'h01);
        n = 0;
        while (core_n !== 1'b0 && n < 8) begin
            step();
            n++;
        end
        check("wdog_cause", cause, 8'h40);
        check("wdog_pull", {7'h0, pull}, 8'h01);
        wait_rel();
        en = 5'h1D;
        feed = 0;
        n = 0;
        while (wexp !== 1'b1 && n < 200) begin
            step();
            n++;
        end
        feed = 1;
        repeat (6) step();
        check("wdog_masked", {7'h0, core_n}, 8'h01);
        check("wdog_masked_cause", cause, 8'h40);
        pd = 1;
        feed = 0;
        n = 0;
        repeat (150) begin
            step();
            if (wexp === 1'b1) n++;
        end
        check("wdog_asleep", n[7:0], 8'h00);
        feed = 1;
        pd = 0;
        arst_n = 0;
        step();
        check("rst_core", {7'h0, core_n}, 8'h00);
        check("rst_cause", cause, 8'h02);
        arst_n = 1;
        wait_rel();
        check("osc_gate2", {7'h0, n >= OSC_DLY}, 8'h01);
        check("cause_after_rst", cause, 8'h02);
        stop_test();
    end
endmodule : tb
